// *** rtl/zrwt_pkg.sv ***
// package: zone read wait timing constants and types
package zrwt_pkg;
    // register map, word aligned byte offsets
    localparam logic [3:0] ZRWT_OFF_TIMING = 4'h0;
    localparam logic [3:0] ZRWT_OFF_CTRL = 4'h4;
    localparam logic [3:0] ZRWT_OFF_STATUS = 4'h8;
    // zone timing register fields
    localparam int ZRWT_SCALE_BIT = 22;
    localparam int ZRWT_RDYMODE_BIT = 15;
    localparam int ZRWT_RDYUSE_BIT = 14;
    localparam int ZRWT_LEAD_HI = 13;
    localparam int ZRWT_LEAD_LO = 12;
    localparam int ZRWT_ACT_HI = 11;
    localparam int ZRWT_ACT_LO = 9;
    localparam int ZRWT_TRAIL_HI = 8;
    localparam int ZRWT_TRAIL_LO = 7;
    // writable bits: scale, ready mode, ready use, lead, active, trail
    localparam logic [31:0] ZRWT_TIMING_MASK = 32'h0040_FF80;
    // scale=1, ready async=1, lead=11, active=111, trail=11
    localparam logic [31:0] ZRWT_TIMING_RESET = 32'h0040_BF80;
    // timing clock divider: one timing tick per (this value + 1) core cycles
    localparam logic [1:0] ZRWT_TICK_DIV_RESET = 2'h0;
    // counter width for phase lengths (max 1 + 2*7; the ready stretch is not counted)
    localparam int ZRWT_CNT_W = 5;
    localparam logic [4:0] ZRWT_CNT_ONE = 5'h01;
    // access sequencer states
    typedef enum logic [2:0] {
        ZRWT_IDLE,
        ZRWT_LEAD,
        ZRWT_ACTIVE,
        ZRWT_READY,
        ZRWT_TRAIL,
        ZRWT_DONE
    } zrwt_state_t;
endpackage : zrwt_pkg

// *** rtl/zrwt_ready_sync.sv ***
// ready input conditioner: two-stage synchroniser plus a direct path
`timescale 1ns/1ps
module zrwt_ready_sync
    import zrwt_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // ready pin and mode
    input wire logic ext_ready_in,
    input wire logic ready_sample_async,
    // conditioned ready
    output logic ready_cond
);
    logic meta_reg;
    logic sync_reg;
    logic direct_reg;

    // async mode pays two cycles of latency to avoid metastability
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
        end else begin
            meta_reg <= ext_ready_in;
            sync_reg <= meta_reg;
        end
    end

    // sync mode trusts the pin to meet setup, one register only
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            direct_reg <= 1'b1;
        end else begin
            direct_reg <= ext_ready_in;
        end
    end

    assign ready_cond = ready_sample_async ? sync_reg : direct_reg;
endmodule : zrwt_ready_sync

// *** rtl/zrwt_core.sv ***
// zone read timing sequencer with avalon-mm register slave
// Contract
// - ready-use 0: ignore ready input
// - ready-use 1: not-ready stretches active phase
// - lead field bits 13:12, doubled when scaled
// - lead codes 1/2/3, default 11 scaled
// - active wait field bits 11:9, doubled scaled
// - active phase is one plus waits
// - active codes 000=0, 001=1, 010=2
// - scale bit 22, resets to one
// - ready-mode bit 15 selects sampling, reset async
// - ready-use enable at bit 14
`timescale 1ns/1ps
module zrwt_core
    import zrwt_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // access request from the core side
    input wire logic rd_req,
    output logic rd_done,
    // external memory side
    input wire logic ext_ready_in,
    output logic ext_rd_strobe_n,
    output logic ext_cs_n,
    output logic wait_timing_clk
);
    logic [31:0] timing_reg;
    logic [1:0] tick_div_reg;
    logic [1:0] div_cnt_reg;
    logic tick;
    logic ack_reg;
    logic [31:0] rdata_reg;
    zrwt_state_t state_reg;
    zrwt_state_t state_next;
    logic [ZRWT_CNT_W-1:0] cnt_reg;
    logic [ZRWT_CNT_W-1:0] cnt_next;
    logic ready_cond;
    logic wait_ext;
    logic scale;
    logic [1:0] lead_code;
    logic [2:0] act_code;
    logic [1:0] trail_code;
    logic [ZRWT_CNT_W-1:0] lead_len;
    logic [ZRWT_CNT_W-1:0] act_len;
    logic [ZRWT_CNT_W-1:0] trail_len;

    // field extraction from the timing register
    assign scale = timing_reg[ZRWT_SCALE_BIT];
    assign lead_code = timing_reg[ZRWT_LEAD_HI:ZRWT_LEAD_LO];
    assign act_code = timing_reg[ZRWT_ACT_HI:ZRWT_ACT_LO];
    assign trail_code = timing_reg[ZRWT_TRAIL_HI:ZRWT_TRAIL_LO];

    // phase lengths in timing ticks; scaling is a left shift
    assign lead_len = {2'b00, lead_code, 1'b0} >> (scale ? 0 : 1);
    assign act_len = ZRWT_CNT_ONE + ({1'b0, act_code, 1'b0} >> (scale ? 0 : 1));
    assign trail_len = {2'b00, trail_code, 1'b0} >> (scale ? 0 : 1);

    // ready pin conditioning, mode picked per zone
    zrwt_ready_sync u_ready (
        .core_clk(core_clk),
        .reset(reset),
        .ext_ready_in(ext_ready_in),
        .ready_sample_async(timing_reg[ZRWT_RDYMODE_BIT]),
        .ready_cond(ready_cond)
    );

    // ready only counts when enabled for the zone
    assign wait_ext = timing_reg[ZRWT_RDYUSE_BIT] & ~ready_cond;

    // timing clock divider; tick marks one timing-clock cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            div_cnt_reg <= 2'h0;
        end else if (div_cnt_reg >= tick_div_reg) begin
            div_cnt_reg <= 2'h0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 2'h1;
        end
    end
    assign tick = (div_cnt_reg >= tick_div_reg);

    // visible timing clock, high for one cycle, the cycle after each tick
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wait_timing_clk <= 1'b0;
        end else begin
            wait_timing_clk <= tick;
        end
    end

    // register writes land on the edge that ends the acknowledged cycle, never earlier
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            timing_reg <= ZRWT_TIMING_RESET;
            tick_div_reg <= ZRWT_TICK_DIV_RESET;
        end else if (avs_write && ack_reg) begin
            if (avs_address == ZRWT_OFF_TIMING) begin
                timing_reg <= avs_writedata & ZRWT_TIMING_MASK;
            end else if (avs_address == ZRWT_OFF_CTRL) begin
                tick_div_reg <= avs_writedata[1:0];
            end
        end
    end

    // one wait state on every access, then ack
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

    // read data mux; unmapped offsets read zero
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            case (avs_address)
                ZRWT_OFF_TIMING: rdata_reg <= timing_reg;
                ZRWT_OFF_CTRL: rdata_reg <= {30'h0000_0000, tick_div_reg};
                ZRWT_OFF_STATUS: rdata_reg <= {24'h00_0000, cnt_reg, state_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end
    assign avs_readdata = rdata_reg;

    // phase sequencer; advances only on timing ticks, except DONE, which returns to IDLE on the next cycle
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ZRWT_IDLE: begin
                if (rd_req && tick) begin
                    state_next = ZRWT_LEAD;
                    cnt_next = lead_len;
                end
            end
            ZRWT_LEAD: begin
                if (tick) begin
                    if (cnt_reg <= ZRWT_CNT_ONE) begin
                        state_next = ZRWT_ACTIVE;
                        cnt_next = act_len;
                    end else begin
                        cnt_next = cnt_reg - ZRWT_CNT_ONE;
                    end
                end
            end
            ZRWT_ACTIVE: begin
                if (tick) begin
                    if (cnt_reg <= ZRWT_CNT_ONE) begin
                        if (wait_ext) begin
                            state_next = ZRWT_READY;
                        end else if (trail_len == '0) begin
                            state_next = ZRWT_DONE;
                        end else begin
                            state_next = ZRWT_TRAIL;
                            cnt_next = trail_len;
                        end
                    end else begin
                        cnt_next = cnt_reg - ZRWT_CNT_ONE;
                    end
                end
            end
            ZRWT_READY: begin
                // stretch lasts while the device holds not-ready
                if (tick && !wait_ext) begin
                    if (trail_len == '0) begin
                        state_next = ZRWT_DONE;
                    end else begin
                        state_next = ZRWT_TRAIL;
                        cnt_next = trail_len;
                    end
                end
            end
            ZRWT_TRAIL: begin
                if (tick) begin
                    if (cnt_reg <= ZRWT_CNT_ONE) begin
                        state_next = ZRWT_DONE;
                    end else begin
                        cnt_next = cnt_reg - ZRWT_CNT_ONE;
                    end
                end
            end
            ZRWT_DONE: begin
                state_next = ZRWT_IDLE;
                cnt_next = '0;
            end
            default: begin
                state_next = ZRWT_IDLE;
                cnt_next = '0;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_reg <= ZRWT_IDLE;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // pin outputs from flip-flops
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ext_cs_n <= 1'b1;
            ext_rd_strobe_n <= 1'b1;
        end else begin
            ext_cs_n <= !(state_next inside {ZRWT_LEAD, ZRWT_ACTIVE, ZRWT_READY,
                ZRWT_TRAIL});
            ext_rd_strobe_n <= !(state_next inside {ZRWT_ACTIVE, ZRWT_READY});
        end
    end
    assign rd_done = (state_reg == ZRWT_DONE);

    // assertions
    a_scale_reset: assert property (@(posedge core_clk)
        $fell(reset) |-> timing_reg[ZRWT_SCALE_BIT] && timing_reg[ZRWT_RDYMODE_BIT])
        else $error("scale or ready mode not one after reset");
    a_ready_ignored: assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == ZRWT_ACTIVE && tick && cnt_reg <= ZRWT_CNT_ONE
            && !timing_reg[ZRWT_RDYUSE_BIT]) |=> state_reg != ZRWT_READY)
        else $error("ready honoured while disabled");
    a_ready_stretch: assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == ZRWT_READY && wait_ext) |=> state_reg == ZRWT_READY)
        else $error("active left while not ready");
    a_lead_len: assert property (@(posedge core_clk) disable iff (reset)
        lead_len == (scale ? {2'b00, lead_code, 1'b0} : {3'b000, lead_code}))
        else $error("lead length wrong");
    a_act_len: assert property (@(posedge core_clk) disable iff (reset)
        act_len == 5'(1 + (scale ? 2 * act_code : act_code)))
        else $error("active length wrong");
    // stretch only ever entered from a zone that uses ready
    a_use_bit: assert property (@(posedge core_clk) disable iff (reset)
        $rose(state_reg == ZRWT_READY) |-> $past(timing_reg[ZRWT_RDYUSE_BIT]))
        else $error("stretch entered without ready use");
    a_mode_sel: assert property (@(posedge core_clk) disable iff (reset)
        timing_reg[ZRWT_RDYMODE_BIT] |-> ready_cond == $past(ext_ready_in, 2))
        else $error("async sampling latency wrong");
    a_mode_sync: assert property (@(posedge core_clk) disable iff (reset)
        !timing_reg[ZRWT_RDYMODE_BIT] |-> ready_cond == $past(ext_ready_in))
        else $error("sync sampling latency wrong");
    sequence s_lead_end;
        state_reg == ZRWT_LEAD ##1 state_reg != ZRWT_LEAD;
    endsequence
    a_phase_order: assert property (@(posedge core_clk) disable iff (reset)
        s_lead_end |-> state_reg == ZRWT_ACTIVE)
        else $error("lead not followed by active");
    a_lead_entry: assert property (@(posedge core_clk) disable iff (reset)
        $rose(state_reg == ZRWT_LEAD) |-> $past(state_reg) == ZRWT_IDLE)
        else $error("lead entered out of order");
    // phase counters load the programmed lengths on entry
    a_lead_load: assert property (@(posedge core_clk) disable iff (reset)
        $rose(state_reg == ZRWT_LEAD) |-> cnt_reg == $past(lead_len))
        else $error("lead count not loaded");
    a_act_load: assert property (@(posedge core_clk) disable iff (reset)
        $rose(state_reg == ZRWT_ACTIVE) |-> cnt_reg == $past(act_len))
        else $error("active count not loaded");
    a_trail_load: assert property (@(posedge core_clk) disable iff (reset)
        $rose(state_reg == ZRWT_TRAIL) |-> cnt_reg == $past(trail_len))
        else $error("trail count not loaded");
    // end of the active count with the device still not ready
    sequence s_active_wait;
        state_reg == ZRWT_ACTIVE && tick && cnt_reg <= ZRWT_CNT_ONE && wait_ext;
    endsequence
    a_stretch_enter: assert property (@(posedge core_clk) disable iff (reset)
        s_active_wait |=> state_reg == ZRWT_READY)
        else $error("ready stretch not entered");
    // pin shape: strobe only inside select, select released while idle
    a_strobe_in_cs: assert property (@(posedge core_clk) disable iff (reset)
        !ext_rd_strobe_n |-> !ext_cs_n)
        else $error("strobe outside select");
    a_cs_idle: assert property (@(posedge core_clk) disable iff (reset)
        state_reg == ZRWT_IDLE |-> ext_cs_n)
        else $error("select held while idle");
    a_done_pulse: assert property (@(posedge core_clk) disable iff (reset)
        rd_done |=> !rd_done)
        else $error("done longer than one cycle");
    // bus handshake: one wait state, write taken on the acknowledged edge
    a_one_wait: assert property (@(posedge core_clk) disable iff (reset)
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("wait state count wrong");
    a_write_land: assert property (@(posedge core_clk) disable iff (reset)
        (avs_write && !avs_waitrequest && avs_address == ZRWT_OFF_TIMING)
            |=> timing_reg == ($past(avs_writedata) & ZRWT_TIMING_MASK))
        else $error("timing write not taken");
endmodule : zrwt_core

// *** verif/zrwt_mem_model.sv ***
// external memory model answering with a ready line
`timescale 1ns/1ps
module zrwt_mem_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // memory side
    input wire logic ext_cs_n,
    input wire logic ext_rd_strobe_n,
    input wire logic [7:0] stall_cycles,
    output logic ext_ready_in
);
    logic [7:0] cnt_reg;
    // not-ready for stall_cycles from select; line toggles while not selected
    // since no pull-up holds it, so a design that looks at it then is caught
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_reg <= 8'h00;
            ext_ready_in <= 1'b1;
        end else if (ext_cs_n) begin
            cnt_reg <= 8'h00;
            ext_ready_in <= ~ext_ready_in;
        end else if (cnt_reg < stall_cycles) begin
            cnt_reg <= cnt_reg + 8'h01;
            ext_ready_in <= 1'b0;
        end else begin
            ext_ready_in <= 1'b1;
        end
    end
endmodule : zrwt_mem_model

// *** verif/zone_read_wait_timing_tb_top.sv ***
// bench for the zone read timing sequencer
`timescale 1ns/1ps
module zone_read_wait_timing_tb_top;
    import zrwt_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic rd_req = 1'b0;
    logic rd_done;
    logic ext_ready_in;
    logic ext_rd_strobe_n;
    logic ext_cs_n;
    logic [7:0] stall_cycles = 8'h00;
    logic tclk;
    int tk;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] q;
    logic [31:0] v;
    int ld;
    int ac;
    int tt;

    always #25 core_clk = ~core_clk;

    zrwt_core uut (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rd_req(rd_req),
        .rd_done(rd_done), .ext_ready_in(ext_ready_in), .ext_rd_strobe_n(ext_rd_strobe_n),
        .ext_cs_n(ext_cs_n), .wait_timing_clk(tclk));

    zrwt_mem_model mem (.core_clk(core_clk), .reset(reset), .ext_cs_n(ext_cs_n),
        .ext_rd_strobe_n(ext_rd_strobe_n), .stall_cycles(stall_cycles),
        .ext_ready_in(ext_ready_in));

    task automatic close_out;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one avalon transfer; request held until a rising edge sees waitrequest low
    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] rd);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= we;
        avs_read <= ~we;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // one idle edge so the next call never reassigns in this time step
        @(posedge core_clk);
    endtask : bus

    // one read access; counts lead, active and whole select time in cycles
    task automatic acc(input logic [7:0] st);
        logic seen;
        seen = 1'b0;
        stall_cycles <= st;
        rd_req <= 1'b1;
        ld = 0;
        ac = 0;
        tt = 0;
        tk = 0;
        for (int i = 0; i < 300; i++) begin
            @(negedge core_clk);
            if (rd_done === 1'b1) begin
                seen = 1'b1;
                break;
            end
            if (ext_cs_n === 1'b0) tt++;
            if (ext_cs_n === 1'b0 && tclk === 1'b1) tk++;
            if (ext_rd_strobe_n === 1'b0) ac++;
            else if (ext_cs_n === 1'b0 && ac == 0) ld++;
        end
        // an access that never finishes counts as a mismatch
        chk(32'(seen), 32'h1);
        @(posedge core_clk);
        rd_req <= 1'b0;
        @(posedge core_clk);
    endtask : acc

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end

    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        bus(1'b0, 4'h0, 32'h0000_0000, q);
        chk(q, 32'h0040_BF80);
        acc(8'h00);
        chk(ld, 6);
        chk(tk, tt);
        chk(ac, 15);
        chk(tt - ld - ac, 6);
        // lead codes 1 to 3 and the low active codes at both scalings
        for (int s = 0; s < 2; s++) begin
            for (int l = 1; l < 4; l++) begin
                v = (32'(s) << 22) | (32'(l) << 12) | (32'(l - 1) << 9) | (32'h1 << 7);
                bus(1'b1, 4'h0, v, q);
                acc(8'h00);
                chk(ld, l << s);
                chk(ac, 1 + ((l - 1) << s));
                chk(tt - ld - ac, 1 << s);
            end
        end
        // stalling device, ready ignored then used, both sampling modes
        for (int m = 0; m < 2; m++) begin
            v = (32'(m) << 15) | (32'h1 << 12) | (32'h2 << 9) | (32'h1 << 7);
            bus(1'b1, 4'h0, v, q);
            acc(8'd12);
            chk(ac, 3);
            bus(1'b1, 4'h0, v | (32'h1 << 14), q);
            acc(8'd12);
            // stall ends 13 cycles after select; sync mode sees it one cycle sooner
            chk(ac, (m == 1) ? 15 : 14);
            chk(tt - ld - ac, 1);
        end
        // reserved bits stay zero, unmapped place reads zero
        bus(1'b1, 4'h0, 32'hFFFF_FFFF, q);
        bus(1'b0, 4'h0, 32'h0000_0000, q);
        chk(q, 32'h0040_FF80);
        bus(1'b1, 4'hC, 32'hFFFF_FFFF, q);
        bus(1'b0, 4'hC, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
        acc(8'h00);
        chk(ac, 15);
        // timing clock at half rate: every phase twice as long in core cycles
        bus(1'b1, 4'h4, 32'h0000_0001, q);
        bus(1'b0, 4'h4, 32'h0000_0000, q);
        chk(q, 32'h0000_0001);
        bus(1'b0, 4'h8, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
        bus(1'b1, 4'h0, (32'h1 << 12) | (32'h1 << 9) | (32'h1 << 7), q);
        acc(8'h00);
        chk(ld, 2);
        chk(ac, 4);
        chk(tt - ld - ac, 2);
        chk(tk, 4);
        close_out();
    end
endmodule : zone_read_wait_timing_tb_top
